// >>> include/qpsd_pkg.sv
package qpsd_pkg;

  // Clock and nonvolatile programming time
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_PER_S = 1000;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYCLES_DFLT = PROG_TIME_MS * (CLK_HZ / MS_PER_S);

  // Address byte and instruction opcodes
  localparam logic [3:0] ADDR_FIXED = 4'h5;
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_SET = 4'hB;
  localparam logic [3:0] OP_WR_SET = 4'hC;
  localparam logic [3:0] OP_RCL_ONE = 4'hD;
  localparam logic [3:0] OP_SAVE_ONE = 4'hE;
  localparam logic [3:0] OP_RCL_ALL = 4'h1;
  localparam logic [3:0] OP_SAVE_ALL = 4'h8;
  localparam logic [3:0] OP_INCDEC = 4'h2;

  // Counts, limits and field values
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [5:0] POS_MAX = 6'h3F;
  localparam logic [5:0] POS_MIN = 6'h00;
  localparam logic [5:0] POS_ONE = 6'h01;
  localparam logic [1:0] SLOT_POWERUP = 2'h0;
  localparam logic [1:0] PAD_ZERO = 2'h0;
  localparam logic [63:0] TAP_ONE = 64'h0000000000000001;
  localparam logic [3:0] MASK_ONE = 4'h1;
  localparam logic [3:0] MASK_ALL = 4'hF;

  // Decoder states
  typedef enum logic [11:0] {
    ST_INIT = 12'h001,
    ST_IDLE = 12'h002,
    ST_ADDR = 12'h004,
    ST_ADDR_ACK = 12'h008,
    ST_INSTR = 12'h010,
    ST_INSTR_ACK = 12'h020,
    ST_WRDATA = 12'h040,
    ST_DATA_ACK = 12'h080,
    ST_RDDATA = 12'h100,
    ST_RD_ACK = 12'h200,
    ST_INCDEC = 12'h400,
    ST_WAITSTOP = 12'h800
  } qpsd_state_t;

  // Whole decoder state
  typedef struct packed {
    qpsd_state_t state;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [3:0] op;
    logic [1:0] settingSelect;
    logic [1:0] potSelect;
    logic pendValid;
    logic dirBit;
    logic sclPrev;
    logic sdaPrev;
    logic sdaOe;
    logic sdaOut;
    logic [3:0][5:0] pos;
    logic [3:0][63:0] tap;
    logic commit;
    logic [3:0] commitMask;
    logic [3:0][5:0] commitData;
  } qpsd_dec_t;

  localparam qpsd_dec_t DEC_RESET = '{state: ST_INIT, tap: {4{TAP_ONE}}, default: '0};

  // One-hot tap switch for a wiper position
  function automatic logic [63:0] decodeTap(input logic [5:0] p);
    decodeTap = TAP_ONE << p;
  endfunction

  // One step up or down, held at the end taps
  function automatic logic [5:0] stepPos(input logic [5:0] p, input logic up);
    if (up) begin
      stepPos = (p == POS_MAX) ? POS_MAX : p + POS_ONE;
    end else begin
      stepPos = (p == POS_MIN) ? POS_MIN : p - POS_ONE;
    end
  endfunction

  // Lane mask for one pot
  function automatic logic [3:0] potMask(input logic [1:0] pot);
    potMask = MASK_ONE << pot;
  endfunction

  // Opcodes that the decoder accepts
  function automatic logic opKnown(input logic [3:0] op);
    opKnown = (op == OP_RD_WIPER) || (op == OP_WR_WIPER) || (op == OP_RD_SET) ||
              (op == OP_WR_SET) || (op == OP_RCL_ONE) || (op == OP_SAVE_ONE) ||
              (op == OP_RCL_ALL) || (op == OP_SAVE_ALL) || (op == OP_INCDEC);
  endfunction

endpackage

// >>> src/qpsd_decoder.sv
// Behaviour
// RQ1: after increment/decrement is acknowledged, clock periods alone step the wiper.
// RQ2: SCL high phase with SDA high moves wiper one step toward high end.
// RQ3: SCL high phase with SDA low moves wiper one step toward low end.
// RQ4: address byte 0101 plus four strap bits; respond only on match.
// RQ5: read wiper returns byte with top two bits zero, position below.
// RQ6: write wiper stores low six bits of data byte and acknowledges.
// RQ7: read setting returns chosen stored setting, top two bits zero.
// RQ8: write setting stores low six bits into chosen stored setting.
// RQ9: global recall loads all wipers from chosen setting after STOP.
// RQ10: global save copies all wipers into chosen setting.
// RQ11: single save copies chosen wiper into chosen setting.
// RQ12: single recall loads chosen wiper from chosen setting.
// RQ13: increment/decrement takes any number of direction bits until STOP.
// RQ14: nonvolatile programming starts only after STOP.
// RQ15: each wiper position drives exactly one of 64 tap switches.
// RQ16: at power-up every wiper loads from its first stored setting.
// RQ17: a stored setting change finishes within five milliseconds.
// RQ18: setting select codes 00 to 11 pick settings zero to three.
// RQ19: stepping saturates at taps 0 and 63.
`timescale 1ns/1ns
`default_nettype none
module qpsd_decoder
  import qpsd_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Serial bus pins
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Address straps
  input wire logic addressStrapBit3,
  input wire logic addressStrapBit2,
  input wire logic addressStrapBit1,
  input wire logic addressStrapBit0,
  // Wiper outputs and status
  output logic [3:0][5:0] wiperPosition,
  output logic [3:0][63:0] wiperTap,
  output logic nvBusy
);

  qpsd_dec_t stReg;
  qpsd_dec_t stNext;
  logic [5:0] pinSync;
  logic [3:0][5:0] rdData;
  logic sclS;
  logic sdaS;
  logic [3:0] strapS;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic [5:0] curPos;

  // Pins through two flops
  qpsd_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .asyncIn({scl, sdaIn, addressStrapBit3, addressStrapBit2, addressStrapBit1, addressStrapBit0}),
    .syncOut(pinSync)
  );

  // Stored settings
  qpsd_nvstore #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_nv (
    .clk_sys(clk_sys),
    .rst(rst),
    .commit(stReg.commit),
    .commitMask(stReg.commitMask),
    .commitSlot(stReg.settingSelect),
    .commitData(stReg.commitData),
    .rdSlot(stReg.settingSelect), // see RQ18
    .rdData(rdData),
    .busy(nvBusy)
  );

  // Bus edges and conditions
  assign sclS = pinSync[5];
  assign sdaS = pinSync[4];
  assign strapS = pinSync[3:0];
  assign sclRise = sclS && !stReg.sclPrev;
  assign sclFall = !sclS && stReg.sclPrev;
  assign startDet = sclS && stReg.sclPrev && stReg.sdaPrev && !sdaS;
  assign stopDet = sclS && stReg.sclPrev && !stReg.sdaPrev && sdaS;
  assign curPos = stReg.pos[stReg.potSelect];

  // Frame decoding and command execution
  always_comb begin
    stNext = stReg;
    stNext.commit = 1'b0;
    stNext.sclPrev = sclS;
    stNext.sdaPrev = sdaS;
    unique case (stReg.state)
      ST_INIT: begin
        stNext.pos = rdData; // see RQ16
        stNext.state = ST_IDLE;
      end
      ST_IDLE, ST_WAITSTOP: begin
      end
      ST_ADDR, ST_INSTR, ST_WRDATA: begin
        if (sclRise && stReg.bitCnt < BYTE_BITS) begin
          stNext.shift = {stReg.shift[6:0], sdaS};
          stNext.bitCnt = stReg.bitCnt + CNT_ONE;
        end else if (sclFall && stReg.bitCnt == BYTE_BITS) begin
          stNext.state = ST_WAITSTOP;
          if (stReg.state == ST_ADDR) begin
            // Busy programming answers with no acknowledge
            if (stReg.shift == {ADDR_FIXED, strapS} && !nvBusy) begin // see RQ4
              stNext.sdaOe = 1'b1;
              stNext.state = ST_ADDR_ACK;
            end
          end else if (stReg.state == ST_INSTR) begin
            if (opKnown(stReg.shift[7:4])) begin
              stNext.op = stReg.shift[7:4];
              stNext.settingSelect = stReg.shift[3:2]; // see RQ18
              stNext.potSelect = stReg.shift[1:0];
              stNext.sdaOe = 1'b1;
              stNext.state = ST_INSTR_ACK;
            end
          end else begin
            stNext.sdaOe = 1'b1;
            stNext.state = ST_DATA_ACK;
            if (stReg.op == OP_WR_WIPER) begin
              stNext.pos[stReg.potSelect] = stReg.shift[5:0]; // see RQ6
            end else begin
              stNext.pendValid = 1'b1; // see RQ8
              stNext.commitData = {4{stReg.shift[5:0]}};
            end
          end
        end
      end
      ST_ADDR_ACK: begin
        if (sclFall) begin
          stNext.sdaOe = 1'b0;
          stNext.bitCnt = CNT_ZERO;
          stNext.state = ST_INSTR;
        end
      end
      ST_INSTR_ACK: begin
        if (sclFall) begin
          stNext.sdaOe = 1'b0;
          stNext.bitCnt = CNT_ZERO;
          if (stReg.op == OP_RD_WIPER || stReg.op == OP_RD_SET) begin
            // First data bit goes out on this same falling edge
            stNext.shift = {PAD_ZERO, (stReg.op == OP_RD_WIPER) ? curPos : rdData[stReg.potSelect]}; // see RQ5 RQ7
            stNext.sdaOe = 1'b1;
            stNext.bitCnt = CNT_ONE;
            stNext.state = ST_RDDATA;
          end else if (stReg.op == OP_WR_WIPER || stReg.op == OP_WR_SET) begin
            stNext.state = ST_WRDATA;
          end else if (stReg.op == OP_INCDEC) begin
            stNext.state = ST_INCDEC; // see RQ1
          end else begin
            stNext.pendValid = 1'b1; // see RQ9 RQ10 RQ11 RQ12
            stNext.state = ST_WAITSTOP;
          end
        end
      end
      ST_RDDATA: begin
        if (sclFall) begin
          if (stReg.bitCnt == BYTE_BITS) begin
            stNext.sdaOe = 1'b0;
            stNext.state = ST_RD_ACK;
          end else begin
            stNext.sdaOe = !stReg.shift[6];
            stNext.shift = {stReg.shift[6:0], 1'b0};
            stNext.bitCnt = stReg.bitCnt + CNT_ONE;
          end
        end
      end
      ST_RD_ACK: begin
        if (sclRise) begin
          stNext.state = ST_WAITSTOP;
        end
      end
      ST_DATA_ACK: begin
        if (sclFall) begin
          stNext.sdaOe = 1'b0;
          stNext.state = ST_WAITSTOP;
        end
      end
      ST_INCDEC: begin
        // Direction caught while high, step taken on the fall
        if (sclRise) begin
          stNext.dirBit = sdaS;
        end else if (sclFall) begin
          stNext.pos[stReg.potSelect] = stepPos(curPos, stReg.dirBit); // see RQ2 RQ3 RQ13 RQ19
        end
      end
    endcase
    // STOP ends any frame and runs a pending transfer
    if (stReg.state != ST_INIT && stopDet) begin
      stNext.state = ST_IDLE;
      stNext.sdaOe = 1'b0;
      stNext.pendValid = 1'b0;
      if (stReg.pendValid) begin
        case (stReg.op)
          OP_RCL_ALL: stNext.pos = rdData; // see RQ9
          OP_RCL_ONE: stNext.pos[stReg.potSelect] = rdData[stReg.potSelect]; // see RQ12
          OP_SAVE_ALL: begin
            stNext.commit = 1'b1; // see RQ10 RQ14
            stNext.commitMask = MASK_ALL;
            stNext.commitData = stReg.pos;
          end
          OP_SAVE_ONE: begin
            stNext.commit = 1'b1; // see RQ11 RQ14
            stNext.commitMask = potMask(stReg.potSelect);
            stNext.commitData = stReg.pos;
          end
          OP_WR_SET: begin
            stNext.commit = 1'b1; // see RQ8 RQ14
            stNext.commitMask = potMask(stReg.potSelect);
          end
          default: begin
          end
        endcase
      end
    end else if (stReg.state != ST_INIT && startDet) begin
      stNext.state = ST_ADDR;
      stNext.bitCnt = CNT_ZERO;
      stNext.sdaOe = 1'b0;
      stNext.pendValid = 1'b0;
    end
    // Tap switches follow the positions
    for (int p = 0; p < 4; p++) begin
      stNext.tap[p] = decodeTap(stNext.pos[p]); // see RQ15
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stReg <= DEC_RESET;
    end else begin
      stReg <= stNext;
    end
  end

  // Outputs
  assign sdaOut = stReg.sdaOut;
  assign sdaOe = stReg.sdaOe;
  assign wiperPosition = stReg.pos;
  assign wiperTap = stReg.tap;

  // Checks
  logic stepNow;
  assign stepNow = stReg.state == ST_INCDEC && sclFall && !stopDet && !startDet;

  AST_INC_STEP: assert property (@(posedge clk_sys) disable iff (rst) // see RQ2
    stepNow && stReg.dirBit && curPos != POS_MAX |=> curPos == $past(curPos) + POS_ONE)
    else $error("increment step missing");

  AST_DEC_STEP: assert property (@(posedge clk_sys) disable iff (rst) // see RQ3
    stepNow && !stReg.dirBit && curPos != POS_MIN |=> curPos == $past(curPos) - POS_ONE)
    else $error("decrement step missing");

  AST_SATURATE: assert property (@(posedge clk_sys) disable iff (rst) // see RQ19
    stepNow && ((stReg.dirBit && curPos == POS_MAX) || (!stReg.dirBit && curPos == POS_MIN))
    |=> $stable(curPos))
    else $error("wiper wrapped at an end tap");

  AST_ADDR_NACK: assert property (@(posedge clk_sys) disable iff (rst) // see RQ4
    stReg.state == ST_ADDR && sclFall && !stopDet && !startDet && stReg.bitCnt == BYTE_BITS &&
    stReg.shift[7:4] != ADDR_FIXED |=> !sdaOe && stReg.state == ST_WAITSTOP)
    else $error("foreign address acknowledged");

  AST_RD_BYTE: assert property (@(posedge clk_sys) disable iff (rst) // see RQ5
    $rose(stReg.state == ST_RDDATA) && stReg.op == OP_RD_WIPER
    |-> stReg.shift == {PAD_ZERO, curPos} && sdaOe ##1 sdaOe)
    else $error("read wiper byte wrong");

  AST_WR_WIPER: assert property (@(posedge clk_sys) disable iff (rst) // see RQ6
    stReg.state == ST_WRDATA && stReg.op == OP_WR_WIPER && sclFall && !stopDet && !startDet &&
    stReg.bitCnt == BYTE_BITS |=> curPos == $past(stReg.shift[5:0]) && sdaOe)
    else $error("wiper write not stored");

  AST_NV_AFTER_STOP: assert property (@(posedge clk_sys) disable iff (rst) // see RQ14
    stReg.commit |-> $past(stopDet) && $past(stReg.pendValid))
    else $error("programming started without STOP");

  AST_TAP_ONEHOT: assert property (@(posedge clk_sys) disable iff (rst) // see RQ15
    $onehot(wiperTap[0]) && $onehot(wiperTap[1]) && $onehot(wiperTap[2]) && $onehot(wiperTap[3]) &&
    wiperTap[0][wiperPosition[0]] && wiperTap[1][wiperPosition[1]] && wiperTap[2][wiperPosition[2]] &&
    wiperTap[3][wiperPosition[3]])
    else $error("tap decode not one-hot");

  AST_POWERUP: assert property (@(posedge clk_sys) disable iff (rst) // see RQ16
    $fell(stReg.state == ST_INIT) |-> wiperPosition == $past(rdData) && stReg.state == ST_IDLE)
    else $error("power-up recall missing");

  AST_GLOBAL_RCL: assert property (@(posedge clk_sys) disable iff (rst) // see RQ9
    stopDet && stReg.pendValid && stReg.op == OP_RCL_ALL |=> wiperPosition == $past(rdData))
    else $error("global recall missing");

  COV_READ: cover property (@(posedge clk_sys) disable iff (rst) stReg.state == ST_RD_ACK);
  COV_STEP: cover property (@(posedge clk_sys) disable iff (rst) stepNow);
  COV_SAVE_ALL: cover property (@(posedge clk_sys) disable iff (rst) stReg.commit && stReg.commitMask == MASK_ALL);
  COV_NACK: cover property (@(posedge clk_sys) disable iff (rst)
    stReg.state == ST_ADDR ##1 stReg.state == ST_WAITSTOP);

endmodule
`default_nettype wire

// >>> src/qpsd_nvstore.sv
`timescale 1ns/1ns
`default_nettype none
module qpsd_nvstore
  import qpsd_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Programming request
  input wire logic commit,
  input wire logic [3:0] commitMask,
  input wire logic [1:0] commitSlot,
  input wire logic [3:0][5:0] commitData,
  // Read port, one setting per pot
  input wire logic [1:0] rdSlot,
  output logic [3:0][5:0] rdData,
  // Programming in progress
  output logic busy
);

  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam logic [TW-1:0] TIMER_LAST = TW'(PROG_CYCLES - 1);
  localparam logic [TW-1:0] TIMER_ONE = TW'(1);

  typedef struct packed {
    logic [3:0][3:0][5:0] cells;
    logic busy;
    logic [TW-1:0] timer;
    logic [3:0] mask;
    logic [1:0] slot;
    logic [3:0][5:0] data;
  } qpsd_nv_t;

  qpsd_nv_t stReg;
  qpsd_nv_t stNext;

  // Latch a request, run the programming timer, write at its end
  always_comb begin
    stNext = stReg;
    if (commit && !stReg.busy) begin
      stNext.busy = 1'b1;
      stNext.timer = '0;
      stNext.mask = commitMask;
      stNext.slot = commitSlot;
      stNext.data = commitData;
    end else if (stReg.busy) begin
      stNext.timer = stReg.timer + TIMER_ONE;
      if (stReg.timer == TIMER_LAST) begin
        stNext.busy = 1'b0; // see RQ17
        for (int p = 0; p < 4; p++) begin
          if (stReg.mask[p]) begin
            stNext.cells[p][stReg.slot] = stReg.data[p];
          end
        end
      end
    end
  end

  // Reset stands for blank cell contents
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stReg <= '0;
    end else begin
      stReg <= stNext;
    end
  end

  // Read mux
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      rdData[p] = stReg.cells[p][rdSlot];
    end
  end

  assign busy = stReg.busy;

  // Length of the current programming cycle
  logic [TW:0] busyLen;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busyLen <= '0;
    end else begin
      busyLen <= stReg.busy ? busyLen + 1'b1 : '0;
    end
  end

  AST_PROG_BOUND: assert property (@(posedge clk_sys) disable iff (rst) // see RQ17
    busyLen <= (TW + 1)'(PROG_CYCLES))
    else $error("programming cycle overran its time");

  COV_PROG_DONE: cover property (@(posedge clk_sys) disable iff (rst) $fell(stReg.busy));

endmodule
`default_nettype wire

// >>> src/qpsd_sync.sv
`timescale 1ns/1ns
`default_nettype none
module qpsd_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Asynchronous inputs and their synchronised copy
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } qpsd_sync_t;

  qpsd_sync_t stReg;
  qpsd_sync_t stNext;

  // Two flops; only the second stage is read
  always_comb begin
    stNext.stage1 = asyncIn;
    stNext.stage2 = stReg.stage1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stReg <= '0;
    end else begin
      stReg <= stNext;
    end
  end

  assign syncOut = stReg.stage2;

endmodule
`default_nettype wire

// >>> test/qpsd_decoder_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module qpsd_decoder_tb_top
  import qpsd_pkg::*;
;
  localparam int PROG = 20;
  logic clk_sys, rst, scl, sdaPull, sdaWire, sdaOut, sdaOe, nvBusy;
  logic [3:0] strapBits;
  logic [7:0] devAddr;
  logic [3:0][5:0] wiperPosition;
  logic [3:0][63:0] wiperTap;
  logic [5:0] vals [4] = '{6'h3F, 6'h00, 6'h15, 6'h2A};
  int mismatches = 0;
  int checked = 0;

  // Open-drain data line with pull-up
  assign sdaWire = ~(sdaOe | sdaPull);
  assign devAddr = {ADDR_FIXED, strapBits};

  // System clock
  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  qpsd_decoder #(.PROG_CYCLES(PROG)) DUT (
    .clk_sys(clk_sys), .rst(rst), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addressStrapBit3(strapBits[3]), .addressStrapBit2(strapBits[2]),
    .addressStrapBit1(strapBits[1]), .addressStrapBit0(strapBits[0]),
    .wiperPosition(wiperPosition), .wiperTap(wiperTap), .nvBusy(nvBusy)
  );

  qpsd_master m (.clk_sys(clk_sys), .sdaWire(sdaWire), .scl(scl), .sdaPull(sdaPull));

  // Compare and count
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Addressed frame with optional data byte and optional close
  task automatic xfer(input logic [7:0] addr, input logic [7:0] ins, input logic [7:0] dat,
                      input logic stop, output logic [7:0] rd, output logic ok);
    logic a0, a1, a2;
    a2 = 1'b1;
    rd = 8'h00;
    m.startCond();
    m.byteOut(addr, a0);
    m.byteOut(ins, a1);
    if (ins[7:4] == OP_RD_WIPER || ins[7:4] == OP_RD_SET) begin
      m.byteIn(rd);
    end else if (ins[7:4] == OP_WR_WIPER || ins[7:4] == OP_WR_SET) begin
      m.byteOut(dat, a2);
    end
    ok = a0 & a1 & a2;
    if (stop) begin
      m.stopCond();
    end
  endtask

  // Bounded wait for the programming cycle to end
  task automatic waitIdle();
    m.waitClk(2);
    for (int i = 0; i < PROG + 40 && nvBusy !== 1'b0; i++) begin
      @(posedge clk_sys);
    end
    check("nvBusy idle", nvBusy, 1'b0);
  endtask

  // Reset state of the pins and wipers
  task automatic testReset();
    for (int p = 0; p < 4; p++) begin
      check("reset wiper", wiperPosition[p], 6'h00);
      check("reset tap", wiperTap[p], 64'h1);
    end
    check("reset busy", {sdaOe, sdaOut, nvBusy}, 3'h0);
    $display("test reset done");
  endtask

  // Address matching, strap changes and unknown opcode
  task automatic testAddress();
    logic [7:0] rd;
    logic ok;
    xfer({ADDR_FIXED, 4'h9}, 8'h90, 8'h00, 1'b1, rd, ok);
    check("wrong strap ack", ok, 1'b0);
    xfer({4'h4, strapBits}, 8'h90, 8'h00, 1'b1, rd, ok);
    check("wrong fixed ack", ok, 1'b0);
    // Each strap bit in turn: new address answers, old one no longer
    for (int b = 0; b < 4; b++) begin
      strapBits <= strapBits ^ 4'(1 << b);
      m.waitClk(4);
      xfer(devAddr, 8'h90, 8'h00, 1'b1, rd, ok);
      check("new strap ack", ok, 1'b1);
      xfer({ADDR_FIXED, 4'h6}, 8'h90, 8'h00, 1'b1, rd, ok);
      check("old strap ack", ok, 1'b0);
      strapBits <= strapBits ^ 4'(1 << b);
      m.waitClk(4);
    end
    xfer(devAddr, 8'h30, 8'h00, 1'b1, rd, ok);
    check("unknown op ack", ok, 1'b0);
    $display("test address done");
  endtask

  // Write and read back every wiper
  task automatic testWiper();
    logic [7:0] rd;
    logic ok;
    for (int p = 0; p < 4; p++) begin
      xfer(devAddr, {OP_WR_WIPER, 2'h0, 2'(p)}, {2'h0, vals[p]}, 1'b1, rd, ok);
      check("write ack", ok, 1'b1);
      check("wiper", wiperPosition[p], vals[p]);
      check("tap", wiperTap[p], 64'h1 << vals[p]);
    end
    for (int p = 0; p < 4; p++) begin
      xfer(devAddr, {OP_RD_WIPER, 2'h0, 2'(p)}, 8'h00, 1'b1, rd, ok);
      check("read wiper", rd, {2'h0, vals[p]});
    end
    $display("test wiper done");
  endtask

  // Stored settings of pot 1, all four slots
  task automatic testSetting();
    logic [7:0] rd;
    logic ok;
    for (int s = 0; s < 4; s++) begin
      xfer(devAddr, {OP_WR_SET, 2'(s), 2'h1}, {2'h0, 4'hC, 2'(s)}, 1'b0, rd, ok);
      check("setting ack", ok, 1'b1);
      m.waitClk(6);
      check("busy before stop", nvBusy, 1'b0);
      m.stopCond();
      m.waitClk(4);
      check("busy after stop", nvBusy, 1'b1);
      waitIdle();
    end
    for (int s = 0; s < 4; s++) begin
      xfer(devAddr, {OP_RD_SET, 2'(s), 2'h1}, 8'h00, 1'b1, rd, ok);
      check("read setting", rd, {2'h0, 4'hC, 2'(s)});
    end
    $display("test setting done");
  endtask

  // Single and global transfers
  task automatic testTransfer();
    logic [7:0] rd;
    logic ok;
    xfer(devAddr, {OP_SAVE_ALL, 2'h2, 2'h0}, 8'h00, 1'b1, rd, ok);
    waitIdle();
    for (int p = 0; p < 4; p++) begin
      xfer(devAddr, {OP_WR_WIPER, 2'h0, 2'(p)}, 8'h00, 1'b1, rd, ok);
    end
    xfer(devAddr, {OP_RCL_ONE, 2'h2, 2'h2}, 8'h00, 1'b1, rd, ok);
    m.waitClk(4);
    check("single recall", wiperPosition, {6'h00, vals[2], 6'h00, 6'h00});
    xfer(devAddr, {OP_RCL_ALL, 2'h2, 2'h0}, 8'h00, 1'b1, rd, ok);
    m.waitClk(4);
    check("global recall", wiperPosition, {vals[3], vals[2], vals[1], vals[0]});
    xfer(devAddr, {OP_SAVE_ONE, 2'h0, 2'h3}, 8'h00, 1'b1, rd, ok);
    waitIdle();
    xfer(devAddr, {OP_RD_SET, 2'h0, 2'h3}, 8'h00, 1'b1, rd, ok);
    check("single save", rd, {2'h0, vals[3]});
    xfer(devAddr, {OP_RD_SET, 2'h0, 2'h2}, 8'h00, 1'b1, rd, ok);
    check("other pot kept", rd, 8'h00);
    $display("test transfer done");
  endtask

  // Stepping mode: eight direction bits, one check per clock
  task automatic testIncDec(input logic [1:0] pot, input logic [5:0] start, input logic [7:0] dirs);
    logic [7:0] rd;
    logic ok, r;
    logic [5:0] exp;
    xfer(devAddr, {OP_WR_WIPER, 2'h0, pot}, {2'h0, start}, 1'b1, rd, ok);
    exp = start;
    xfer(devAddr, {OP_INCDEC, 2'h0, pot}, 8'h00, 1'b0, rd, ok);
    check("incdec ack", ok, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      m.bitIO(dirs[i], r);
      m.waitClk(5);
      if (dirs[i]) begin
        exp = (exp == 6'h3F) ? exp : exp + 6'h01;
      end else begin
        exp = (exp == 6'h00) ? exp : exp - 6'h01;
      end
      check("incdec step", wiperPosition[pot], exp);
    end
    m.stopCond();
    m.waitClk(4);
    check("incdec end", wiperPosition[pot], exp);
    $display("test incdec done");
  endtask

  // Watchdog
  initial begin
    repeat (80000) @(posedge clk_sys);
    mismatches++;
    $display("ERROR watchdog expected end of tests seen none");
    finish_test();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    strapBits = 4'h6;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    testReset();
    testAddress();
    testWiper();
    testSetting();
    testTransfer();
    testIncDec(2'h0, 6'h3D, 8'hE3);
    testIncDec(2'h1, 6'h02, 8'h1C);
    finish_test();
  end
endmodule
`default_nettype wire

// >>> test/qpsd_master.sv
`timescale 1ns/1ns
`default_nettype none
module qpsd_master (
  // Clock of the bench
  input wire logic clk_sys,
  // Bus lines
  input wire logic sdaWire,
  output logic scl,
  output logic sdaPull
);
  // Idle bus: clock stands high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end

  // Wait a number of system clocks
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One clock period; data moves only while the clock is low
  task automatic bitIO(input logic b, output logic r);
    waitClk(1);
    sdaPull <= ~b;
    waitClk(3);
    scl <= 1'b1;
    waitClk(2);
    r = sdaWire;
    waitClk(2);
    scl <= 1'b0;
  endtask

  // Frame opening, also usable as a repeated start
  task automatic startCond();
    waitClk(1);
    sdaPull <= 1'b0;
    waitClk(2);
    scl <= 1'b1;
    waitClk(4);
    sdaPull <= 1'b1; // Data falls while clock high
    waitClk(4);
    scl <= 1'b0;
  endtask

  // Frame close; a clock high phase cut by it carries no step
  task automatic stopCond();
    waitClk(1);
    sdaPull <= 1'b1;
    waitClk(3);
    scl <= 1'b1;
    waitClk(4);
    sdaPull <= 1'b0; // Ends any mode or transfer
    waitClk(4);
  endtask

  // Byte out, most significant bit first, then the device's acknowledge
  task automatic byteOut(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIO(v[i], r);
    end
    bitIO(1'b1, r);
    ack = (r === 1'b0);
  endtask

  // Byte in with line released, then a not-acknowledge
  task automatic byteIn(output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIO(1'b1, v[i]);
    end
    bitIO(1'b1, r);
  endtask
endmodule
`default_nettype wire
